// file: plc_pkg.sv
/*
  Shared constants and types for the two-rate line codec (B3ZS and CMI).
  Assumes a single 25 MHz core clock; line timing is measured in core cycles.
*/
`default_nettype none
package plc_pkg;
  localparam int unsigned CORE_HZ          = 25_000_000;
  localparam int unsigned RATE3_KBPS       = 44_736;
  localparam int unsigned RATE4_KBPS       = 139_264;
  localparam int unsigned TOL3_PPM         = 20;
  localparam int unsigned TOL4_PPM         = 15;
  localparam int unsigned ALARM_LIMIT_US   = 250;
  localparam int unsigned ALARM_LIMIT_CYC  = ALARM_LIMIT_US * (CORE_HZ / 1_000_000);
  localparam int unsigned ALARM_LAT_CYC    = 2;
  localparam int unsigned UI3_CYC_DEF      = 4;
  localparam int unsigned HALF4_CYC_DEF    = 2;
  localparam int unsigned LOSS_UI_DEF      = 32;
  localparam logic        POL_RST          = 1'b0;
  localparam logic [7:0]  PHASE_RST        = 8'h00;
  localparam logic [2:0]  WIN_RST          = 3'h0;
  localparam logic [9:0]  CNT_RST          = 10'h000;

  typedef enum logic [1:0] {
    SLOT_PLAIN = 2'b00,
    SLOT_ZERO  = 2'b01,
    SLOT_VIOL  = 2'b10
  } plc_slot_e;

  typedef struct packed {
    logic pos;
    logic neg;
  } plc_bipolar_s;

  typedef struct packed {
    logic data;
    logic clk;
    logic alarm;
    logic report;
  } plc_rx_s;

  localparam plc_bipolar_s LINE_IDLE = '{pos: 1'b0, neg: 1'b0};
  localparam plc_rx_s      RX_RST    = '{data: 1'b1, clk: 1'b0, alarm: 1'b0, report: 1'b0};
endpackage
`default_nettype wire

// file: plc_line_codec.sv
/*
  Line codec for a 44 736 kbit/s B3ZS port and a 139 264 kbit/s CMI port:
  encoders, timing recovery, decoders, signal-absence supervision and alarm substitution.
  Assumes transmit bit strobes from path termination on core_clk_i and line inputs
  from outside the clock domain; line rates are scaled by the cycle parameters.
*/
`default_nettype none
module plc_line_codec
  import plc_pkg::*;
#(
  parameter int unsigned UI3_CYC        = UI3_CYC_DEF,
  parameter int unsigned HALF4_CYC      = HALF4_CYC_DEF,
  parameter int unsigned LOSS_UI        = LOSS_UI_DEF,
  parameter int unsigned ALARM_LIMIT    = ALARM_LIMIT_CYC
) (
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         supervision_monitored_i,
  input  wire logic         tx3_data_i,
  input  wire logic         tx3_stb_i,
  output plc_bipolar_s      tx3_line_o,
  input  wire logic         tx4_data_i,
  input  wire logic         tx4_stb_i,
  output logic              tx4_line_o,
  input  wire plc_bipolar_s rx3_line_i,
  output plc_rx_s           rx3_o,
  input  wire logic         rx4_line_i,
  output plc_rx_s           rx4_o
);
  localparam logic [7:0] UI3_LEN   = 8'(UI3_CYC);
  localparam logic [7:0] HALF4_LEN = 8'(HALF4_CYC);
  localparam logic [9:0] LOSS3     = 10'(LOSS_UI);
  localparam logic [9:0] LOSS4     = 10'(2 * LOSS_UI);

  if (UI3_CYC < 4 || UI3_CYC > 255 || HALF4_CYC < 2 || HALF4_CYC > 255)
    $error("line cycle parameters out of range");
  if (LOSS_UI < 2 || LOSS_UI > 511 || ALARM_LIMIT < ALARM_LAT_CYC)
    $error("supervision parameters out of range");

  // free-running phase, pulled in by line edges; nominal period when idle
  function automatic logic [7:0] phase_next(input logic [7:0] ph, input logic edge_seen, input logic [7:0] len);
    if (edge_seen)
      return 8'h01;
    else if (ph == len - 8'h01)
      return 8'h00;
    else
      return ph + 8'h01;
  endfunction

  function automatic logic [9:0] loss_next(input logic [9:0] cnt, input logic edge_seen, input logic smp,
                                           input logic [9:0] lim);
    if (edge_seen)
      return 10'h000;
    else if (smp && cnt < lim)
      return cnt + 10'h001;
    else
      return cnt;
  endfunction

  // ---------------- B3ZS transmit
  logic      [2:0] tx_win;
  plc_slot_e       tx_slot2, tx_slot1;
  logic            tx_last_pol, tx_odd;
  wire logic       sub_start = tx_slot2 == SLOT_PLAIN && tx_slot1 == SLOT_PLAIN && tx_win == 3'h0;
  wire logic       is_viol   = tx_slot2 == SLOT_VIOL;
  wire logic       tx_pulse  = (tx_slot2 == SLOT_PLAIN && tx_win[2]) || (sub_start && !tx_odd) || is_viol;
  wire logic       tx_pol    = is_viol ? tx_last_pol : !tx_last_pol;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_win      <= WIN_RST;
      tx_slot2    <= SLOT_PLAIN;
      tx_slot1    <= SLOT_PLAIN;
      tx_last_pol <= POL_RST;
      tx_odd      <= 1'b0;
      tx3_line_o  <= LINE_IDLE;
    end else if (tx3_stb_i) begin
      tx_win      <= {tx_win[1:0], tx3_data_i};
      tx_slot2    <= sub_start ? SLOT_ZERO : tx_slot1;
      tx_slot1    <= sub_start ? SLOT_VIOL : SLOT_PLAIN;
      tx3_line_o  <= '{pos: tx_pulse && tx_pol, neg: tx_pulse && !tx_pol};
      if (tx_pulse)
        tx_last_pol <= tx_pol;
      if (is_viol)
        tx_odd <= 1'b0;
      else if (tx_pulse)
        tx_odd <= !tx_odd;
    end
  end

  // ---------------- CMI transmit
  logic tx4_half, tx4_bit, tx4_one_lvl;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx4_half    <= 1'b0;
      tx4_bit     <= 1'b0;
      tx4_one_lvl <= 1'b1;
      tx4_line_o  <= 1'b0;
    end else if (tx4_stb_i) begin
      tx4_half <= !tx4_half;
      if (!tx4_half) begin
        tx4_bit    <= tx4_data_i;
        tx4_line_o <= tx4_data_i ? tx4_one_lvl : 1'b0;
      end else begin
        tx4_line_o <= tx4_bit ? tx4_one_lvl : 1'b1;
        if (tx4_bit)
          tx4_one_lvl <= !tx4_one_lvl;
      end
    end
  end

  // ---------------- line input synchronisers
  plc_bipolar_s rx3_m, rx3_s, rx3_p;
  logic         rx4_m, rx4_s, rx4_p;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx3_m <= LINE_IDLE;
      rx3_s <= LINE_IDLE;
      rx3_p <= LINE_IDLE;
      rx4_m <= 1'b0;
      rx4_s <= 1'b0;
      rx4_p <= 1'b0;
    end else begin
      rx3_m <= rx3_line_i;
      rx3_s <= rx3_m;
      rx3_p <= rx3_s;
      rx4_m <= rx4_line_i;
      rx4_s <= rx4_m;
      rx4_p <= rx4_s;
    end
  end

  // ---------------- B3ZS receive
  logic [7:0] ph3;
  logic [9:0] cnt3;
  logic [2:0] dpipe;
  logic       rx_last_pol;
  wire logic  edge3 = (rx3_s.pos && !rx3_p.pos) || (rx3_s.neg && !rx3_p.neg);
  wire logic  smp3  = ph3 == (UI3_LEN >> 1);
  wire logic  mark3 = rx3_s.pos || rx3_s.neg;
  wire logic  viol3 = mark3 && (rx3_s.pos == rx_last_pol);
  wire logic  def3  = cnt3 >= LOSS3;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph3         <= PHASE_RST;
      cnt3        <= CNT_RST;
      dpipe       <= WIN_RST;
      rx_last_pol <= POL_RST;
      rx3_o       <= RX_RST;
    end else begin
      ph3       <= phase_next(ph3, edge3, UI3_LEN);
      cnt3      <= loss_next(cnt3, edge3, smp3, LOSS3);
      rx3_o.clk <= ph3 < (UI3_LEN >> 1);
      rx3_o.report <= def3 && supervision_monitored_i;
      if (smp3) begin
        dpipe <= viol3 ? 3'h0 : {dpipe[1:0], mark3};
        if (mark3)
          rx_last_pol <= rx3_s.pos;
      end
      rx3_o.alarm <= def3;
      if (def3)
        rx3_o.data <= 1'b1;
      else if (smp3)
        rx3_o.data <= dpipe[2];
    end
  end

  // ---------------- CMI receive
  logic [7:0] ph4;
  logic [9:0] cnt4;
  logic       hsel, first_half;
  wire logic  edge4 = rx4_s != rx4_p;
  wire logic  smp4  = ph4 == (HALF4_LEN >> 1);
  wire logic  def4  = cnt4 >= LOSS4;
  wire logic  slip4 = hsel && first_half && !rx4_s;
  wire logic  bit4  = first_half == rx4_s;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph4        <= PHASE_RST;
      cnt4       <= CNT_RST;
      hsel       <= 1'b0;
      first_half <= 1'b0;
      rx4_o      <= RX_RST;
    end else begin
      ph4          <= phase_next(ph4, edge4, HALF4_LEN);
      cnt4         <= loss_next(cnt4, edge4, smp4, LOSS4);
      rx4_o.report <= def4 && supervision_monitored_i;
      rx4_o.alarm  <= def4;
      if (smp4) begin
        first_half <= rx4_s;
        hsel       <= slip4 ? 1'b1 : !hsel;
        rx4_o.clk  <= hsel && !slip4;
      end
      if (def4)
        rx4_o.data <= 1'b1;
      else if (smp4 && hsel && !slip4)
        rx4_o.data <= bit4;
    end
  end

  // ---------------- checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_loss3;
    $rose(def3);
  endsequence
  sequence s_back3;
    $fell(def3);
  endsequence

  viol_same_pol_a: assert property (tx3_stb_i && is_viol |=>
    (tx3_line_o.pos || tx3_line_o.neg) && tx3_line_o.pos == $past(tx_last_pol))
    else $error("violation pulse polarity wrong");
  ami_alternate_a: assert property (tx3_stb_i && tx_slot2 == SLOT_PLAIN && tx_win[2] |=>
    tx3_line_o.pos == !$past(tx_last_pol) && tx3_line_o.neg == $past(tx_last_pol))
    else $error("mark polarity did not alternate");
  sub_odd_zero_a: assert property (tx3_stb_i && sub_start && tx_odd |=>
    !tx3_line_o.pos && !tx3_line_o.neg ##0 tx_slot2 == SLOT_ZERO && tx_slot1 == SLOT_VIOL)
    else $error("odd run not coded as 00V");
  cmi_zero_a: assert property (tx4_stb_i && !tx4_half && !tx4_data_i |=> !tx4_line_o)
    else $error("CMI zero first half not low");
  cmi_zero_high_a: assert property (tx4_stb_i && tx4_half && !tx4_bit |=> tx4_line_o)
    else $error("CMI zero second half not high");
  cmi_one_a: assert property (tx4_stb_i && !tx4_half && tx4_data_i |=>
    tx4_line_o == $past(tx4_one_lvl))
    else $error("CMI one level wrong");
  b3zs_undo_a: assert property (smp3 && viol3 |=> dpipe == 3'h0)
    else $error("substitution not removed");
  loss3_set_a: assert property (smp3 && !edge3 && cnt3 == LOSS3 - 10'h001 |=> def3)
    else $error("absence not detected");
  loss4_set_a: assert property (smp4 && !edge4 && cnt4 == LOSS4 - 10'h001 |=> def4)
    else $error("CMI absence not detected");
  alarm_entry_a: assert property (s_loss3 |-> ##[1:2] rx3_o.alarm && rx3_o.data)
    else $error("all ones not applied in time");
  alarm_exit_a: assert property (s_back3 |-> ##[1:2] !rx3_o.alarm)
    else $error("all ones not removed in time");
  report_gate_a: assert property ((!supervision_monitored_i)[*2] |-> !rx3_o.report && !rx4_o.report)
    else $error("report while unmonitored");
  subst_clock_a: assert property (def3 && ph3 == UI3_LEN - 8'h01 && !edge3 |=> ph3 == 8'h00)
    else $error("substitute clock period wrong");
endmodule
`default_nettype wire

// file: plc_line_partner.sv
/*
  Coaxial line model between the codec's transmit and receive ports, looped back.
  Assumes the bench cuts the line to create signal absence; a cut line carries no pulses.
*/
`default_nettype none
module plc_line_partner
  import plc_pkg::*;
(
  input  wire logic         cut_i,
  input  wire plc_bipolar_s tx3_line_i,
  input  wire logic         tx4_line_i,
  output var  plc_bipolar_s rx3_line_o,
  output var  logic         rx4_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // loopback keeps the transmitter's own rate and code
  assign rx3_line_o = cut_i ? LINE_IDLE : tx3_line_i;
  assign rx4_line_o = cut_i ? 1'b0 : tx4_line_i;
endmodule
`default_nettype wire

// file: plc_line_codec_test.sv
/*
  Self-checking bench for the two-rate line codec, receive fed back from transmit.
  Assumes plc_pkg, plc_line_codec and plc_line_partner; scaled UI and loss counts.
*/
`default_nettype none
module plc_line_codec_test
  import plc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          LIM  = 100;
  localparam logic [17:0] E3   = 18'h10662;
  localparam logic [9:0]  E4   = 10'h1D3;
  localparam logic [11:0] PAT3 = 12'h8C0;
  localparam logic [4:0]  PAT4 = 5'h0B;
  logic         clk = 1'b0, nrst = 1'b0, sup = 1'b0, cut = 1'b0, run = 1'b0;
  logic         tx3_d = 1'b0, tx3_s = 1'b0, tx4_d = 1'b0, tx4_s = 1'b0, p3 = 1'b0, p4 = 1'b0;
  logic         tx4_line, rx4_line;
  logic [15:0]  s4 = 16'h0000;
  logic [63:0]  sh3 = 64'h0, sh4 = 64'h0;
  plc_bipolar_s tx3_line, rx3_line;
  plc_bipolar_s s3 [16];
  plc_rx_s      rx3, rx4;
  int           cyc = 0, n3 = 0, n4 = 0, miscompares = 0, num_checks = 0;

  plc_line_codec #(.UI3_CYC(4), .HALF4_CYC(2), .LOSS_UI(4), .ALARM_LIMIT(LIM)) dut (
    .core_clk_i(clk), .nrst_i(nrst), .supervision_monitored_i(sup),
    .tx3_data_i(tx3_d), .tx3_stb_i(tx3_s), .tx3_line_o(tx3_line),
    .tx4_data_i(tx4_d), .tx4_stb_i(tx4_s), .tx4_line_o(tx4_line),
    .rx3_line_i(rx3_line), .rx3_o(rx3), .rx4_line_i(rx4_line), .rx4_o(rx4));
  plc_line_partner line (.cut_i(cut), .tx3_line_i(tx3_line), .tx4_line_i(tx4_line),
    .rx3_line_o(rx3_line), .rx4_line_o(rx4_line));

  initial begin
    forever #20 clk = ~clk;
  end

  // strobes, payload, line capture and decoded-bit capture
  always @(negedge clk) begin
    if (run) begin
      tx3_s = (cyc % 4 == 0);
      tx4_s = (cyc % 2 == 0);
      if (tx3_s) begin
        if (n3 < 16) s3[n3] = tx3_line;
        tx3_d = PAT3[11 - n3 % 12];
        n3++;
      end
      if (tx4_s) begin
        if (n4 < 16) s4[n4] = tx4_line;
        tx4_d = PAT4[4 - (n4 / 2) % 5];
        n4++;
      end
      cyc++;
    end
    if (rx3.clk && !p3 && !rx3.alarm) sh3 = {sh3[62:0], rx3.data};
    if (rx4.clk && !p4 && !rx4.alarm) sh4 = {sh4[62:0], rx4.data};
    p3 = rx3.clk;
    p4 = rx4.clk;
  end

  task automatic chk_bit(string what, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_sym(string what, plc_bipolar_s exp, plc_bipolar_s got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // symbol k of the stream shows on the line before strobe k+4
  task automatic test_tx();
    for (int i = 0; i < 100 && n3 < 14; i++) @(negedge clk);
    for (int j = 0; j < 9; j++) chk_sym("b3zs symbol", E3[17 - 2 * j -: 2], s3[j + 4]);
    for (int j = 0; j < 10; j++) chk_bit("cmi half", E4[9 - j], s4[j + 1]);
  endtask

  task automatic test_rx();
    logic f3 = 1'b0;
    logic f4 = 1'b0;
    repeat (300) @(negedge clk);
    for (int i = 0; i < 53; i++) begin
      f3 |= (sh3[i +: 12] === PAT3);
      f4 |= (sh4[i +: 10] === 10'h16B);
    end
    chk_bit("b3zs decode", 1'b1, f3);
    chk_bit("cmi decode", 1'b1, f4);
    chk_bit("rx3 alarm idle", 1'b0, rx3.alarm);
    chk_bit("rx4 alarm idle", 1'b0, rx4.alarm);
  endtask

  task automatic test_loss(logic mon);
    int   t = 0;
    int   r3 = 0;
    int   r4 = 0;
    logic d = 1'b1;
    sup = mon;
    cut = 1'b1;
    while (t < LIM && !(rx3.alarm === 1'b1 && rx4.alarm === 1'b1)) begin
      @(negedge clk);
      t++;
    end
    repeat (2) @(negedge clk);
    chk_bit("rx3 alarm", 1'b1, rx3.alarm);
    chk_bit("rx4 alarm", 1'b1, rx4.alarm);
    repeat (20) begin
      @(negedge clk);
      r3 += rx3.clk;
      r4 += rx4.clk;
      d &= rx3.data & rx4.data;
    end
    chk_bit("all ones", 1'b1, d);
    chk_bit("rx3 ref clock", 1'b1, r3 > 0 && r3 < 20);
    chk_bit("rx4 ref clock", 1'b1, r4 > 0 && r4 < 20);
    chk_bit("rx3 report", mon, rx3.report);
    chk_bit("rx4 report", mon, rx4.report);
    sup = !mon;
    repeat (3) @(negedge clk);
    chk_bit("rx3 report flip", !mon, rx3.report);
    chk_bit("rx4 report flip", !mon, rx4.report);
    cut = 1'b0;
    t = 0;
    while (t < LIM && (rx3.alarm !== 1'b0 || rx4.alarm !== 1'b0)) begin
      @(negedge clk);
      t++;
    end
    repeat (2) @(negedge clk);
    chk_bit("rx3 alarm end", 1'b0, rx3.alarm);
    chk_bit("rx4 alarm end", 1'b0, rx4.alarm);
    chk_bit("rx3 report end", 1'b0, rx3.report);
  endtask

  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    run = 1'b1;
    test_tx();
    test_rx();
    test_loss(1'b1);
    test_loss(1'b0);
    end_sim();
  end

  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
